// file: tpw_timer.sv
// 8-bit interval / pwm / carrier timer with apb register access
//
// Operation
// [RULE1] interval mode: period match raises interrupt and clears counter
// [RULE2] interval mode: width register matches are not detected at all
// [RULE3] interval mode with output enabled: 50% square wave, toggle per match
// [RULE4] run bit set starts counting from zero; clearing it stops
// [RULE5] period match clear, toggle and interrupt occur on a count clock
// [RULE6] clearing run returns interrupt and output to default low
// [RULE7] period zero in interval mode: interrupt only once after start
// [RULE8] software keeps period fixed while counting in pwm mode
// [RULE9] pwm period match: clear, interrupt, toggle, then compare width
// [RULE10] pwm width match: toggle, compare period, no clear, no interrupt
// [RULE11] pwm cycle is period plus one count clocks
// [RULE12] width written while running applies at old match after 3 clocks
// [RULE13] width writes accepted any time, regardless of count clock phase
// [RULE14] software rewrites width before each restart
// [RULE15] software keeps width below period in pwm mode
// [RULE16] pwm output stays default until the first compare match
// [RULE17] three-bit clock select picks count clock; latch needs three clocks
// [RULE18] carrier mode: period sets low width, width sets high width
// [RULE19] software keeps period fixed while counting in carrier mode
// [RULE20] carrier output appears only while the gating counter allows
// [RULE21] gate off gives low, gate alone high, gate with remote gives carrier
// [RULE22] synced gating event copies buffer gate bit on second count clock
// [RULE23] running counter steps by one per count clock, cleared by match
// [RULE24] after reset counter is zero, stopped, outputs low
`timescale 1ns/100ps
module tpw_timer import tpw_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // gating counter event
    input wire logic gating_counter_interrupt,
    // timer outputs
    output logic timer_output_pin,
    output logic match_interrupt
);

    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("tpw_timer: ADDR_W must reach the register map");
        end
    endgenerate

    tpw_state_t s, next_s;
    logic tick;
    logic synced_gating_interrupt;
    logic carrier_gate_active;
    logic [7:0] match_val;
    logic hit;
    logic zero_hold;
    logic take_wr;
    logic mapped;
    logic [7:0] addr;
    logic [DATA_W-1:0] rd_val;

    // count clock from the selected divide ratio
    tpw_prescale #(
        .PRE_W(7)
    ) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(s.md.count_run_bit),
        .sel(s.md.count_clock_select), // RULE17
        .tick(tick)
    );

    // gate bit transfer from the gating counter event
    tpw_gate_sync u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .gating_counter_interrupt(gating_counter_interrupt),
        .carrier_gate_buffer(s.gbuf),
        .synced_gating_interrupt(synced_gating_interrupt),
        .carrier_gate_active(carrier_gate_active)
    );

    // compare target and match detection
    assign match_val = (s.sel == CMP_WIDTH) ? s.width_compare
                                            : s.period_compare;
    assign hit = s.cnt == match_val;
    assign zero_hold = (s.md.mode == MODE_INTERVAL) && s.zero_done
                       && (s.period_compare == CNT_ZERO);

    // apb decode
    assign addr = paddr[7:0];
    assign take_wr = psel && penable && s.ready && pwrite && !s.err;
    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        case (addr)
            REG_MODE: rd_val = DATA_W'(s.md);
            REG_PERIOD: rd_val = DATA_W'(s.period_compare);
            REG_WIDTH: rd_val = DATA_W'(s.pend ? s.width_new
                                               : s.width_compare);
            REG_CARRIER: rd_val = DATA_W'({carrier_gate_active, s.gbuf,
                                           s.rmc});
            REG_STATUS: rd_val = DATA_W'({synced_gating_interrupt, s.sel,
                                          s.lvl, s.cnt});
            default: mapped = 1'b0;
        endcase
    end

    // counter, compare, output and register update
    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        next_s.ready = 1'b0;
        next_s.err = 1'b0;
        if (!s.md.count_run_bit) begin
            next_s.cnt = CNT_ZERO; // RULE4
            next_s.sel = CMP_PERIOD;
            next_s.lvl = 1'b0; // RULE6
            next_s.zero_done = 1'b0;
        end else if (tick) begin
            next_s.cnt = s.cnt + CNT_ONE; // RULE23
            if (s.pend && s.age < WIDTH_LAT_CYC) begin
                next_s.age = s.age + AGE_ONE; // RULE17
            end
            case (s.md.mode)
                MODE_PWM: begin
                    if (hit && s.sel == CMP_PERIOD) begin
                        next_s.cnt = CNT_ZERO; // RULE9 RULE11
                        next_s.irq = 1'b1;
                        next_s.lvl = !s.lvl; // RULE16
                        next_s.sel = CMP_WIDTH;
                    end else if (hit) begin
                        next_s.lvl = !s.lvl; // RULE10
                        next_s.sel = CMP_PERIOD;
                        if (s.pend && s.age >= WIDTH_LAT_CYC) begin
                            next_s.width_compare = s.width_new; // RULE12
                            next_s.pend = 1'b0;
                        end
                    end
                end
                MODE_CARRIER: begin
                    if (hit) begin
                        next_s.cnt = CNT_ZERO; // RULE18
                        next_s.irq = 1'b1;
                        next_s.lvl = !s.lvl;
                        next_s.sel = (s.sel == CMP_PERIOD) ? CMP_WIDTH
                                                           : CMP_PERIOD;
                        if (s.sel == CMP_WIDTH && s.pend
                            && s.age >= WIDTH_LAT_CYC) begin
                            next_s.width_compare = s.width_new; // RULE12
                            next_s.pend = 1'b0;
                        end
                    end
                end
                default: begin
                    // interval: width register never compared
                    if (hit) begin // RULE2
                        next_s.cnt = CNT_ZERO; // RULE1 RULE5
                        if (!zero_hold) begin
                            next_s.irq = 1'b1; // RULE7
                            next_s.lvl = !s.lvl; // RULE3
                            next_s.zero_done = 1'b1;
                        end
                    end
                end
            endcase
        end

        // apb answer one cycle after setup
        if (psel && !penable) begin
            next_s.ready = 1'b1;
            next_s.err = !mapped;
            next_s.rdata = rd_val;
        end
        if (take_wr) begin
            case (addr)
                REG_MODE: next_s.md = tpw_mode_t'(pwdata[MODE_W-1:0]);
                REG_PERIOD: next_s.period_compare = pwdata[CNT_W-1:0];
                REG_WIDTH: begin
                    if (s.md.count_run_bit) begin
                        next_s.width_new = pwdata[CNT_W-1:0]; // RULE13
                        next_s.pend = 1'b1;
                        next_s.age = '0;
                    end else begin
                        next_s.width_compare = pwdata[CNT_W-1:0]; // RULE14
                        next_s.pend = 1'b0;
                    end
                end
                REG_CARRIER: begin
                    next_s.gbuf = pwdata[1];
                    next_s.rmc = pwdata[0];
                end
                default: next_s.rdata = s.rdata;
            endcase
        end

        // pin level, gated by enable and in carrier mode by the gate
        if (s.md.mode == MODE_CARRIER) begin
            next_s.pin = s.md.pin_output_enable && carrier_gate_active
                         && (!s.rmc || next_s.lvl); // RULE20 RULE21
        end else begin
            next_s.pin = s.md.pin_output_enable && next_s.lvl; // RULE3
        end
        if (!s.md.count_run_bit) begin
            next_s.pin = 1'b0; // RULE6
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0; // RULE24
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.err;
    assign timer_output_pin = s.pin;
    assign match_interrupt = s.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    stop_default_a: assert property ( // RULE6
        !s.md.count_run_bit |=> !match_interrupt && !timer_output_pin
                                && s.cnt == CNT_ZERO)
        else $error("stopped timer not at default");
    interval_clear_a: assert property ( // RULE1
        s.md.count_run_bit && tick && s.md.mode == MODE_INTERVAL && hit
        && !zero_hold |=> match_interrupt && s.cnt == CNT_ZERO)
        else $error("interval match did not clear and interrupt");
    interval_toggle_a: assert property ( // RULE3
        s.md.count_run_bit && tick && s.md.mode == MODE_INTERVAL && hit
        && !zero_hold |=> s.lvl != $past(s.lvl))
        else $error("interval match did not toggle");
    width_ignored_a: assert property ( // RULE2
        s.md.count_run_bit && tick && s.md.mode == MODE_INTERVAL
        && s.cnt == s.width_compare && !hit |=> !match_interrupt
        && $stable(s.lvl))
        else $error("width match acted in interval mode");
    zero_once_a: assert property ( // RULE7
        s.md.count_run_bit && zero_hold |=> !match_interrupt)
        else $error("repeated interrupt with zero period");
    pwm_period_a: assert property ( // RULE9
        s.md.count_run_bit && tick && s.md.mode == MODE_PWM && hit
        && s.sel == CMP_PERIOD |=> match_interrupt && s.cnt == CNT_ZERO
        && s.sel == CMP_WIDTH)
        else $error("pwm period match wrong");
    pwm_width_a: assert property ( // RULE10
        s.md.count_run_bit && tick && s.md.mode == MODE_PWM && hit
        && s.sel == CMP_WIDTH |=> !match_interrupt && s.sel == CMP_PERIOD
        && s.cnt - $past(s.cnt) == CNT_ONE)
        else $error("pwm width match wrong");
    width_latch_a: assert property ( // RULE12
        s.md.count_run_bit && s.pend && s.age < WIDTH_LAT_CYC
        |=> $stable(s.width_compare))
        else $error("width applied too early");
    count_step_a: assert property ( // RULE23
        s.md.count_run_bit && tick && !hit |=> s.cnt - $past(s.cnt)
                                               == CNT_ONE)
        else $error("counter did not step by one");
    gate_low_a: assert property ( // RULE21
        s.md.mode == MODE_CARRIER && !carrier_gate_active
        |=> !timer_output_pin)
        else $error("carrier pin high with gate off");

    // count clock, start, width latch and carrier checks
    count_edge_a: assert property ( // RULE5
        s.md.count_run_bit && !tick
        |=> !match_interrupt && $stable(s.lvl))
        else $error("match action off the count clock");
    run_start_a: assert property ( // RULE4
        $rose(s.md.count_run_bit)
        |-> s.cnt == CNT_ZERO && !timer_output_pin)
        else $error("counting did not start from zero");
    pwm_hold_a: assert property ( // RULE16
        s.md.count_run_bit && tick && s.md.mode == MODE_PWM && !hit
        |=> $stable(s.lvl))
        else $error("pwm level moved without a match");
    pwm_width_tog_a: assert property ( // RULE10
        s.md.count_run_bit && tick && s.md.mode == MODE_PWM && hit
        && s.sel == CMP_WIDTH |=> s.lvl != $past(s.lvl))
        else $error("pwm width match did not toggle");
    width_apply_a: assert property ( // RULE12
        s.md.count_run_bit && tick && s.md.mode == MODE_PWM && hit
        && s.sel == CMP_WIDTH && s.pend && s.age == WIDTH_LAT_CYC && !take_wr
        |=> s.width_compare == $past(s.width_new) && !s.pend)
        else $error("latched width not applied at match");
    width_take_a: assert property ( // RULE13
        take_wr && addr == REG_WIDTH && s.md.count_run_bit
        |=> s.pend && s.width_new == $past(pwdata[CNT_W-1:0]))
        else $error("running width write not latched");
    carrier_flip_a: assert property ( // RULE18
        s.md.count_run_bit && tick && s.md.mode == MODE_CARRIER && hit
        |=> s.cnt == CNT_ZERO && s.lvl != $past(s.lvl)
            && s.sel != $past(s.sel))
        else $error("carrier match did not swap widths");
    gate_alone_a: assert property ( // RULE21
        s.md.count_run_bit && s.md.mode == MODE_CARRIER && !s.rmc
        && s.md.pin_output_enable && carrier_gate_active
        |=> timer_output_pin)
        else $error("carrier pin not high with gate alone");

endmodule // tpw_timer

// file: tpw_pkg.sv
// shared constants, register map and state types of the interval/pwm timer
package tpw_pkg;

    // register byte offsets
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_WIDTH = 8'h08;
    localparam logic [7:0] REG_CARRIER = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // reset values and widths
    localparam logic [7:0] PERIOD_RST = 8'h00;
    localparam logic [7:0] WIDTH_RST = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam int CNT_W = 8;
    localparam int DATA_W = 32;

    // count clocks a latched width value must wait before use
    localparam logic [1:0] WIDTH_LAT_CYC = 2'h3;
    localparam logic [1:0] AGE_ONE = 2'h1;

    // operating modes
    typedef enum logic [1:0] {
        MODE_INTERVAL,
        MODE_PWM,
        MODE_CARRIER,
        MODE_SPARE
    } tpw_mode_sel_t;

    // which compare register the counter is checked against
    typedef enum logic {
        CMP_PERIOD,
        CMP_WIDTH
    } tpw_cmp_t;

    // mode control register layout, run bit lowest
    typedef struct packed {
        logic [2:0] count_clock_select;
        tpw_mode_sel_t mode;
        logic pin_output_enable;
        logic count_run_bit;
    } tpw_mode_t;

    // carrier control register layout
    typedef struct packed {
        logic carrier_gate_active;
        logic carrier_gate_buffer;
        logic remote_control_mode;
    } tpw_carrier_t;

    localparam int MODE_W = $bits(tpw_mode_t);
    localparam int CARR_W = $bits(tpw_carrier_t);

    // whole state of the timer core
    typedef struct packed {
        tpw_mode_t md;
        logic rmc;
        logic gbuf;
        logic [7:0] period_compare;
        logic [7:0] width_compare;
        logic [7:0] width_new;
        logic pend;
        logic [1:0] age;
        logic [7:0] cnt;
        tpw_cmp_t sel;
        logic lvl;
        logic zero_done;
        logic irq;
        logic pin;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } tpw_state_t;

endpackage

// file: tpw_prescale.sv
// count clock divider, one pclk enable pulse per count clock
`timescale 1ns/100ps
module tpw_prescale import tpw_pkg::*; #(
    parameter int PRE_W = 7
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [2:0] sel,
    // count clock enable
    output logic tick
);

    generate
        if (PRE_W < 7) begin : g_bad_w
            $error("tpw_prescale: PRE_W must cover divide by 128");
        end
    endgenerate

    typedef struct packed {
        logic [PRE_W-1:0] div;
        logic tick;
    } tpw_pre_t;

    tpw_pre_t s, next_s;
    logic [PRE_W-1:0] mask;

    // divide by two to the power of the select field
    always_comb begin
        mask = PRE_W'((1 << sel) - 1);
        next_s = s;
        next_s.tick = 1'b0;
        if (!run) begin
            next_s.div = '0;
        end else begin
            next_s.div = s.div + PRE_W'(1);
            next_s.tick = (s.div & mask) == mask;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule // tpw_prescale

// file: tpw_gate_sync.sv
// gating counter event sync and buffered gate bit transfer
`timescale 1ns/100ps
module tpw_gate_sync import tpw_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // count clock enable
    input wire logic tick,
    // gating counter side
    input wire logic gating_counter_interrupt,
    input wire logic carrier_gate_buffer,
    // results
    output logic synced_gating_interrupt,
    output logic carrier_gate_active
);

    typedef struct packed {
        logic pend;
        logic sync;
        logic dly;
        logic active;
    } tpw_gate_t;

    tpw_gate_t s, next_s;

    // event held until the next count clock, then copied two clocks on
    always_comb begin
        next_s = s;
        if (tick) begin
            next_s.sync = s.pend;
            next_s.dly = s.sync;
            next_s.pend = 1'b0;
            if (s.dly) begin
                next_s.active = carrier_gate_buffer; // RULE22
            end
        end
        if (gating_counter_interrupt) begin
            next_s.pend = 1'b1; // set wins over the clear
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign synced_gating_interrupt = s.sync;
    assign carrier_gate_active = s.active;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    gate_copy_a: assert property ( // RULE22
        tick && s.sync |=> s.dly)
        else $error("gate copy sequence broken");
    gate_xfer_a: assert property ( // RULE22
        tick && s.dly |=> carrier_gate_active == $past(carrier_gate_buffer))
        else $error("gate bit not transferred");
    gate_event_a: assert property (
        tick && s.pend |=> synced_gating_interrupt)
        else $error("gating event lost");

endmodule // tpw_gate_sync

// file: tpw_pin_load.sv
// load on the timer output pin, measures level widths
`timescale 1ns/100ps
module tpw_pin_load (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // observed pin
    input wire logic pin,
    // last finished widths in pclk cycles, rising edges
    output logic [15:0] hi_w,
    output logic [15:0] lo_w,
    output logic [15:0] rises
);
    logic [15:0] run_w;
    logic last;
    // time each level, store it when the pin changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_w <= 16'h1;
            last <= 1'b0;
            hi_w <= 16'h0;
            lo_w <= 16'h0;
            rises <= 16'h0;
        end else begin
            last <= pin;
            run_w <= (pin != last) ? 16'h1 : run_w + 16'h1;
            if (pin != last && last)
                hi_w <= run_w;
            if (pin != last && !last)
                lo_w <= run_w;
            if (pin && !last)
                rises <= rises + 16'h1;
        end
    end
endmodule // tpw_pin_load

// file: tb_top.sv
// self-checking bench of the interval/pwm/carrier timer
`timescale 1ns/100ps
module tb_top import tpw_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic gating_counter_interrupt = 1'b0;
    logic timer_output_pin;
    logic match_interrupt;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic [15:0] rises;
    logic [15:0] gap_run = 16'h0;
    logic [15:0] irq_gap = 16'h0;
    logic [15:0] irq_cnt = 16'h0;
    logic [31:0] r;
    logic [15:0] c0;
    logic slv;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    tpw_timer tpw_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gating_counter_interrupt(gating_counter_interrupt),
        .timer_output_pin(timer_output_pin),
        .match_interrupt(match_interrupt)
    );
    tpw_pin_load tpw_pin_load_i (
        .pclk(pclk), .presetn(presetn), .pin(timer_output_pin),
        .hi_w(hi_w), .lo_w(lo_w), .rises(rises)
    );

    // interrupt spacing, count and hang limit
    always @(posedge pclk) begin
        gap_run <= match_interrupt ? 16'h1 : gap_run + 16'h1;
        if (match_interrupt === 1'b1) begin
            irq_gap <= gap_run;
            irq_cnt <= irq_cnt + 16'h1;
        end
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready high ends this wait; if it never comes, only the bench timeout does
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic pulse_gate();
        gating_counter_interrupt <= 1'b1;
        @(posedge pclk);
        gating_counter_interrupt <= 1'b0;
    endtask

    function automatic logic [31:0] mk(logic [2:0] c, tpw_mode_sel_t m,
                                       logic run);
        tpw_mode_t v;
        v = '{count_clock_select: c, mode: m, pin_output_enable: 1'b1,
              count_run_bit: run};
        return {25'h0, v};
    endfunction

    // main sequence
    initial begin
        tk(6);
        presetn <= 1'b1;
        tk(1);
        // reset state and unmapped access
        apb(1'b0, REG_STATUS, 32'h0, r);
        chk(r, 32'h0);
        apb(1'b0, REG_MODE, 32'h0, r);
        chk(r, 32'h0);
        chk(32'(timer_output_pin), 32'h0);
        apb(1'b0, 8'h14, 32'h0, r);
        chk(32'(slv), 32'h1);
        $display("reset test done");
        // interval mode, width register must not matter
        wr(REG_PERIOD, 32'h3);
        wr(REG_WIDTH, 32'h1);
        wr(REG_MODE, mk(3'h0, MODE_INTERVAL, 1'b1));
        tk(40);
        chk(32'(irq_gap), 32'h4);
        chk(32'(hi_w), 32'h4);
        chk(32'(lo_w), 32'h4);
        wr(REG_MODE, mk(3'h0, MODE_INTERVAL, 1'b0));
        tk(2);
        chk(32'(timer_output_pin), 32'h0);
        chk(32'(match_interrupt), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0, r);
        chk(r & 32'hFF, 32'h0);
        // period zero gives one interrupt only
        wr(REG_PERIOD, 32'h0);
        wr(REG_WIDTH, 32'h1);
        c0 = irq_cnt;
        wr(REG_MODE, mk(3'h0, MODE_INTERVAL, 1'b1));
        tk(40);
        chk(32'(irq_cnt - c0), 32'h1);
        wr(REG_MODE, mk(3'h0, MODE_INTERVAL, 1'b0));
        $display("interval test done");
        // pwm, count clock every second pclk
        wr(REG_PERIOD, 32'h9);
        wr(REG_WIDTH, 32'h3);
        wr(REG_MODE, mk(3'h1, MODE_PWM, 1'b1));
        tk(4);
        chk(32'(timer_output_pin), 32'h0);
        tk(100);
        chk(32'(irq_gap), 32'd20);
        chk(32'(hi_w), 32'd8);
        chk(32'(lo_w), 32'd12);
        wr(REG_WIDTH, 32'h5);
        tk(100);
        chk(32'(hi_w), 32'd12);
        chk(32'(lo_w), 32'd8);
        wr(REG_MODE, mk(3'h1, MODE_PWM, 1'b0));
        $display("pwm test done");
        // carrier with remote mode and gate set
        wr(REG_CARRIER, 32'h3);
        wr(REG_PERIOD, 32'h2);
        wr(REG_WIDTH, 32'h4);
        wr(REG_MODE, mk(3'h0, MODE_CARRIER, 1'b1));
        pulse_gate();
        tk(60);
        apb(1'b0, REG_CARRIER, 32'h0, r);
        chk(r, 32'h7);
        chk(32'(lo_w), 32'h3);
        chk(32'(hi_w), 32'h5);
        // gate cleared: pin held low
        wr(REG_CARRIER, 32'h1);
        pulse_gate();
        tk(20);
        c0 = rises;
        tk(20);
        chk(32'(rises), 32'(c0));
        chk(32'(timer_output_pin), 32'h0);
        // gate alone: pin held high
        wr(REG_CARRIER, 32'h2);
        pulse_gate();
        tk(20);
        chk(32'(timer_output_pin), 32'h1);
        $display("carrier test done");
        tally_and_finish();
    end
endmodule // tb_top
